// file: wol_pkg.sv
// constants, types and register map of the write-once option latches
// assumes a single 25 MHz clock domain; crystal-clock cycles are counted on clk_in
package wol_pkg;

    // ****************************************
    // register map (index; byte address is four times the index)
    // ****************************************
    localparam logic [5:0]  WOL_IDX_LATCH_TWO = 6'h1E;
    localparam logic [5:0]  WOL_IDX_LATCH_ONE = 6'h1F;
    localparam logic [5:0]  WOL_IDX_STATUS    = 6'h20;
    localparam int          WOL_ADDR_W        = 8;

    // ****************************************
    // option_latch_one fields
    // ****************************************
    localparam int WOL_B_WDOG_RATE   = 7;
    localparam int WOL_B_LV_STOP_EN  = 6;
    localparam int WOL_B_LV_RST_DIS  = 5;
    localparam int WOL_B_LV_PWR_DIS  = 4;
    localparam int WOL_B_LV_MODE     = 3;
    localparam int WOL_B_SHORT_REC   = 2;
    localparam int WOL_B_STOP_PERMIT = 1;
    localparam int WOL_B_WDOG_DIS    = 0;

    // ****************************************
    // option_latch_two fields
    // ****************************************
    localparam int WOL_B_OSC_RUN     = 0;
    localparam int WOL_B_BAUD_SRC    = 1;

    // ****************************************
    // status register fields
    // ****************************************
    localparam int WOL_B_ST_LOCK_ONE = 0;
    localparam int WOL_B_ST_LOCK_TWO = 1;
    localparam int WOL_B_ST_MODE_LK  = 2;
    localparam int WOL_B_ST_STOPPED  = 3;
    localparam int WOL_B_ST_RECOVER  = 4;

    // ****************************************
    // reset values and counts
    // ****************************************
    localparam logic [7:0]  WOL_RST_OPT       = 8'h00;
    localparam logic [31:0] WOL_RST_RDATA     = 32'h0000_0000;
    localparam int          WOL_REC_SHORT_CYC = 32;
    localparam int          WOL_REC_LONG_CYC  = 4096;
    localparam int          WOL_REC_W         = 13;
    localparam logic [17:0] WOL_WDOG_FAST_CYC = 18'd8176;
    localparam logic [17:0] WOL_WDOG_SLOW_CYC = 18'd262128;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        WOL_RUN     = 2'b00,
        WOL_STOPPED = 2'b01,
        WOL_RECOVER = 2'b10
    } wol_mode_t;

    typedef struct packed {
        logic                  read;
        logic                  write;
        logic [WOL_ADDR_W-1:0] address;
        logic [31:0]           writedata;
        logic [3:0]            byteenable;
    } wol_av_req_t;

    typedef struct packed {
        logic       osc_enable;
        logic       clkgen_hold;
        logic       baud_bus_clk;
        logic       wdog_enable;
        logic [17:0] wdog_timeout;
        logic       lvd_power;
        logic       lvd_reset;
        logic       lvd_trip_5v;
    } wol_ctrl_t;

    typedef struct packed {
        logic [7:0]  opt1;
        logic [7:0]  opt2;
        logic        lock1;
        logic        lock2;
        logic        mode_lock;
        wol_mode_t   mode;
        logic        wait_req;
        logic [31:0] rdata;
        logic        lvd_s1;
        logic        lvd_s2;
        wol_ctrl_t   ctrl;
        logic        illegal;
        logic        resume;
        logic        rec_start;
        logic        rec_long;
    } wol_state_t;

    typedef struct packed {
        logic [WOL_REC_W-1:0] cnt;
        logic                 busy;
        logic                 done;
    } wol_timer_t;

endpackage

// file: wol_recovery_timer.sv
// stop-recovery delay counter: one start pulse, one done pulse after the delay
// assumes start is only pulsed while idle
`timescale 1ns/100ps
module wol_recovery_timer
(
    // clock and reset
    input  wire logic clk_in,
    input  wire logic nrst_in,
    // control
    input  wire logic start_in,
    input  wire logic long_in,
    // status
    output logic      busy_out,
    output logic      done_out
);
    import wol_pkg::*;

    wol_timer_t s_q;
    wol_timer_t s_d;

    always_comb
    begin
        s_d      = s_q;
        s_d.done = 1'b0;
        if (!nrst_in)
        begin
            s_d = '0;
        end
        else if (start_in && !s_q.busy)
        begin
            s_d.busy = 1'b1;
            s_d.cnt  = long_in ? WOL_REC_W'(WOL_REC_LONG_CYC - 1) : WOL_REC_W'(WOL_REC_SHORT_CYC - 1);
        end
        else if (s_q.busy)
        begin
            // done lands the chosen number of cycles plus one after the start pulse
            if (s_q.cnt == '0)
            begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end
            else
            begin
                s_d.cnt = s_q.cnt - WOL_REC_W'(1);
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        s_q <= s_d;
    end

    assign busy_out = s_q.busy;
    assign done_out = s_q.done;

endmodule

// file: wol_option_latches.sv
// write-once option latches with avalon-mm slave and derived control outputs
// assumes por_in comes from the reset controller on clk_in and is high with
// nrst_in low when the reset is a power-on reset
//
// Added by the designer: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/100ps
module wol_option_latches
(
    // clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 nrst_in,
    input  wire logic                 por_in,
    // avalon-mm slave
    input  wire wol_pkg::wol_av_req_t av_req_in,
    output logic [31:0]               av_readdata_out,
    output logic                      av_waitrequest_out,
    // processor and detector events
    input  wire logic                 stop_req_in,
    input  wire logic                 wake_in,
    input  wire logic                 wake_by_lvd_in,
    input  wire logic                 lvd_trip_in,
    // control outputs
    output wol_pkg::wol_ctrl_t        ctrl_out,
    output logic                      illegal_opcode_out,
    output logic                      cpu_resume_out
);
    import wol_pkg::*;

    // ****************************************
    // state
    // ****************************************
    wol_state_t s_q;
    wol_state_t s_d;
    logic       rec_busy;
    logic       rec_done;

    function automatic logic hit(input logic [WOL_ADDR_W-1:0] addr, input logic [5:0] idx);
        hit = (addr[WOL_ADDR_W-1:2] == idx);
    endfunction

    wol_recovery_timer u_timer
    (
        .clk_in   (clk_in),
        .nrst_in  (nrst_in),
        .start_in (s_q.rec_start),
        .long_in  (s_q.rec_long),
        .busy_out (rec_busy),
        .done_out (rec_done)
    );

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        logic        acc;
        logic        wr;
        logic        stopped;
        logic [7:0]  wd;
        s_d           = s_q;
        acc           = (av_req_in.read || av_req_in.write) && s_q.wait_req;
        wr            = av_req_in.write && !s_q.wait_req && av_req_in.byteenable[0];
        wd            = av_req_in.writedata[7:0];
        stopped       = 1'b0;
        s_d.illegal   = 1'b0;
        s_d.resume    = 1'b0;
        s_d.rec_start = 1'b0;
        s_d.lvd_s1    = lvd_trip_in;
        s_d.lvd_s2    = s_q.lvd_s1;
        if (!nrst_in)
        begin
            s_d.opt1      = WOL_RST_OPT;
            s_d.opt2      = WOL_RST_OPT;
            s_d.opt1[WOL_B_LV_MODE] = por_in ? 1'b0 : s_q.opt1[WOL_B_LV_MODE];
            s_d.mode_lock = por_in ? 1'b0 : s_q.mode_lock;
            s_d.lock1     = 1'b0;
            s_d.lock2     = 1'b0;
            s_d.mode      = WOL_RUN;
            s_d.wait_req  = 1'b1;
            s_d.rdata     = WOL_RST_RDATA;
            s_d.lvd_s1    = 1'b0;
            s_d.lvd_s2    = 1'b0;
            s_d.rec_long  = 1'b0;
        end
        else
        begin
            // ****************************************
            // bus slave: fixed two-cycle answer
            // ****************************************
            if (acc)
            begin
                s_d.wait_req = 1'b0;
                s_d.rdata    = WOL_RST_RDATA;
                if (hit(av_req_in.address, WOL_IDX_LATCH_ONE))
                begin
                    s_d.rdata[7:0] = s_q.opt1;
                end
                else if (hit(av_req_in.address, WOL_IDX_LATCH_TWO))
                begin
                    s_d.rdata[7:0] = s_q.opt2;
                end
                else if (hit(av_req_in.address, WOL_IDX_STATUS))
                begin
                    s_d.rdata[WOL_B_ST_LOCK_ONE] = s_q.lock1;
                    s_d.rdata[WOL_B_ST_LOCK_TWO] = s_q.lock2;
                    s_d.rdata[WOL_B_ST_MODE_LK]  = s_q.mode_lock;
                    s_d.rdata[WOL_B_ST_STOPPED]  = (s_q.mode == WOL_STOPPED);
                    s_d.rdata[WOL_B_ST_RECOVER]  = (s_q.mode == WOL_RECOVER);
                end
            end
            else
            begin
                s_d.wait_req = 1'b1;
            end
            // a write takes effect only at the edge where waitrequest is seen low
            if (wr && hit(av_req_in.address, WOL_IDX_LATCH_ONE) && !s_q.lock1)
            begin
                s_d.opt1  = wd;
                s_d.lock1 = 1'b1;
                s_d.opt1[WOL_B_LV_MODE] = s_q.mode_lock ? s_q.opt1[WOL_B_LV_MODE] : wd[WOL_B_LV_MODE];
                s_d.mode_lock = 1'b1;
            end
            if (wr && hit(av_req_in.address, WOL_IDX_LATCH_TWO) && !s_q.lock2)
            begin
                s_d.opt2  = wd;
                s_d.lock2 = 1'b1;
            end

            // ****************************************
            // stop mode sequencing
            // ****************************************
            case (s_q.mode)
                WOL_RUN:
                begin
                    if (stop_req_in && s_q.opt1[WOL_B_STOP_PERMIT])
                    begin
                        s_d.mode = WOL_STOPPED;
                    end
                    else if (stop_req_in)
                    begin
                        s_d.illegal = 1'b1;
                    end
                end
                WOL_STOPPED:
                begin
                    stopped = 1'b1;
                    if (wake_in)
                    begin
                        s_d.mode      = WOL_RECOVER;
                        s_d.rec_start = 1'b1;
                        // long delay unless short chosen and the wake is not a detector reset
                        s_d.rec_long  = !s_q.opt1[WOL_B_SHORT_REC] || wake_by_lvd_in;
                    end
                end
                WOL_RECOVER:
                begin
                    if (rec_done && !s_q.rec_start)
                    begin
                        s_d.mode   = WOL_RUN;
                        s_d.resume = 1'b1;
                    end
                end
                default:
                begin
                    s_d.mode = WOL_RUN;
                end
            endcase
            if (s_d.mode == WOL_STOPPED)
            begin
                stopped = 1'b1;
            end
        end

        // ****************************************
        // derived controls, registered so every output leaves a flop
        // ****************************************
        s_d.ctrl.osc_enable   = !stopped || s_d.opt2[WOL_B_OSC_RUN];
        s_d.ctrl.clkgen_hold  = stopped && !s_d.opt2[WOL_B_OSC_RUN];
        s_d.ctrl.baud_bus_clk = s_d.opt2[WOL_B_BAUD_SRC];
        s_d.ctrl.wdog_enable  = !s_d.opt1[WOL_B_WDOG_DIS];
        s_d.ctrl.wdog_timeout = s_d.opt1[WOL_B_WDOG_RATE] ? WOL_WDOG_FAST_CYC : WOL_WDOG_SLOW_CYC;
        s_d.ctrl.lvd_power    = !s_d.opt1[WOL_B_LV_PWR_DIS]
                                && (!stopped || s_d.opt1[WOL_B_LV_STOP_EN]);
        // trip input is asynchronous, so only the second sync stage is used
        s_d.ctrl.lvd_reset    = s_q.lvd_s2 && s_d.ctrl.lvd_power
                                && !s_d.opt1[WOL_B_LV_RST_DIS];
        s_d.ctrl.lvd_trip_5v  = s_d.opt1[WOL_B_LV_MODE];
        if (!nrst_in)
        begin
            s_d.ctrl.lvd_reset = 1'b0;
        end
    end

    always_ff @(posedge clk_in)
    begin
        s_q <= s_d;
    end

    // ****************************************
    // outputs
    // ****************************************
    assign av_readdata_out    = s_q.rdata;
    assign av_waitrequest_out = s_q.wait_req;
    assign ctrl_out           = s_q.ctrl;
    assign illegal_opcode_out = s_q.illegal;
    assign cpu_resume_out     = s_q.resume;

endmodule

// file: wol_option_latches_asserts.sv
// port checker for the write-once option latches
// assumes it is bound onto wol_option_latches, one clock domain
`timescale 1ns/100ps
module wol_option_latches_asserts
(
    // clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 nrst_in,
    // bus and events
    input  wire wol_pkg::wol_av_req_t av_req_in,
    input  wire logic [31:0]          av_readdata_out,
    input  wire logic                 av_waitrequest_out,
    input  wire logic                 stop_req_in,
    // watched outputs
    input  wire wol_pkg::wol_ctrl_t   ctrl_out,
    input  wire logic                 illegal_opcode_out,
    input  wire logic                 cpu_resume_out
);
    import wol_pkg::*;
    // ****************************************
    // properties
    // ****************************************
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);
    a_wait_answer: assert property ((av_req_in.read || av_req_in.write) && av_waitrequest_out
        |=> !av_waitrequest_out)
        else $error("request not answered next cycle");
    a_wait_single: assert property (!av_waitrequest_out |=> av_waitrequest_out)
        else $error("waitrequest low longer than one cycle");
    a_reset_idle: assert property ($past(!nrst_in) |-> av_waitrequest_out && !illegal_opcode_out
        && !cpu_resume_out && !ctrl_out.lvd_reset)
        else $error("outputs not idle after reset");
    a_rdata_upper: assert property (!av_waitrequest_out |-> av_readdata_out[31:8] == 24'h00_0000)
        else $error("upper read data not zero");
    a_wdog_values: assert property (ctrl_out.wdog_timeout == WOL_WDOG_FAST_CYC
        || ctrl_out.wdog_timeout == WOL_WDOG_SLOW_CYC)
        else $error("watchdog timeout not a legal count");
    // option-derived controls only move after a bus answer or a reset
    a_ctrl_cause: assert property ($changed({ctrl_out.baud_bus_clk, ctrl_out.wdog_timeout,
        ctrl_out.lvd_trip_5v}) |-> $past(!av_waitrequest_out) || $past(!av_waitrequest_out, 2)
        || $past(!nrst_in) || $past(!nrst_in, 2))
        else $error("option control changed without a write");
    a_hold_osc: assert property (!ctrl_out.osc_enable |-> ctrl_out.clkgen_hold)
        else $error("oscillator off without clock hold");
    a_lvd_off: assert property (!ctrl_out.lvd_power |-> !ctrl_out.lvd_reset)
        else $error("unpowered detector requests reset");
    a_illegal_cause: assert property (illegal_opcode_out |-> $past(stop_req_in) && !$past(illegal_opcode_out))
        else $error("illegal opcode without stop request");
    a_resume_pulse: assert property (cpu_resume_out |=> !cpu_resume_out)
        else $error("resume longer than one cycle");
endmodule
bind wol_option_latches wol_option_latches_asserts wol_option_latches_asserts_i (.clk_in(clk_in), .nrst_in(nrst_in),
    .av_req_in(av_req_in), .av_readdata_out(av_readdata_out), .av_waitrequest_out(av_waitrequest_out),
    .stop_req_in(stop_req_in), .ctrl_out(ctrl_out), .illegal_opcode_out(illegal_opcode_out),
    .cpu_resume_out(cpu_resume_out));

// file: tb_wol_option_latches.sv
// self-checking bench for the write-once option latches
// assumes wol_pkg and the design are compiled first
`timescale 1ns/100ps
module tb_wol_option_latches;
    import wol_pkg::*;
    // ****************************************
    // signals and design
    // ****************************************
    logic        clk_in, nrst_in, por_in, stop_req_in, wake_in, wake_by_lvd_in, lvd_trip_in;
    wol_av_req_t av_req;
    wol_ctrl_t   ctrl;
    logic [31:0] rdata, seed, v1, v2, e1, q;
    logic        wreq, ill, res, mode_exp, mode_lk, lb, por;
    int          n_fail, comparisons, cyc, n, d;

    wol_option_latches wol_option_latches_i (.clk_in(clk_in), .nrst_in(nrst_in), .por_in(por_in),
        .av_req_in(av_req), .av_readdata_out(rdata), .av_waitrequest_out(wreq), .stop_req_in(stop_req_in),
        .wake_in(wake_in), .wake_by_lvd_in(wake_by_lvd_in), .lvd_trip_in(lvd_trip_in), .ctrl_out(ctrl),
        .illegal_opcode_out(ill), .cpu_resume_out(res));

    initial
    begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // expected controls from stored options, detector trip and stop state
    function automatic wol_ctrl_t exp_ctrl(input logic [7:0] o1, input logic [7:0] o2, input logic t, input logic s);
        wol_ctrl_t c;
        c.osc_enable   = !s || o2[0];
        c.clkgen_hold  = s && !o2[0];
        c.baud_bus_clk = o2[1];
        c.wdog_enable  = !o1[0];
        c.wdog_timeout = o1[7] ? WOL_WDOG_FAST_CYC : WOL_WDOG_SLOW_CYC;
        c.lvd_power    = !o1[4] && (!s || o1[6]);
        c.lvd_reset    = t && !o1[5] && c.lvd_power;
        c.lvd_trip_5v  = o1[3];
        return c;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        comparisons++;
        if (got !== exp)
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        if (got !== exp)
            n_fail++;
    endtask

    task automatic finish_test();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // one access; an edge passes after release so strobes never toggle twice in a step
    task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] wd);
        av_req.read      <= rd;
        av_req.write     <= !rd;
        av_req.address   <= a;
        av_req.writedata <= wd;
        @(posedge clk_in);
        while (wreq !== 1'b0)
            @(posedge clk_in);
        q = rdata;
        av_req.read  <= 1'b0;
        av_req.write <= 1'b0;
        @(posedge clk_in);
    endtask

    task automatic do_reset(input logic p);
        nrst_in <= 1'b0;
        por_in  <= p;
        repeat (2) @(posedge clk_in);
        nrst_in <= 1'b1;
        por_in  <= 1'b0;
        @(posedge clk_in);
        if (p)
            mode_lk = 1'b0;
        if (p)
            mode_exp = 1'b0;
    endtask

    always @(posedge clk_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            $display("[FAIL] %0t timeout", $time);
            n_fail++;
            finish_test();
        end
    end

    // ****************************************
    // tests
    // ****************************************
    initial
    begin
        {nrst_in, stop_req_in, wake_in, wake_by_lvd_in, lvd_trip_in} = 5'h0;
        por_in = 1'b1;
        av_req = '0;
        av_req.byteenable = 4'hF;
        seed = 32'hc690_ad36;
        {n_fail, comparisons} = {32'h0, 32'h0};
        @(posedge clk_in);
        for (int it = 0; it < 8; it++)
        begin
            seed = lfsr(seed);
            // mode bit set after power-on, then two plain resets must keep it
            v1 = (it == 0) ? (seed | 32'h0000_0008) : (it == 1) ? 32'h0000_00FF : (it == 2) ? 32'h0
                : (it == 3) ? 32'h0000_0006 : seed;
            v2 = lfsr(seed) | {31'h0, v1[2]};
            por = (it == 0) || (it > 2 && seed[8]);
            do_reset(por);
            bus(1'b1, 8'h7C, 32'h0);
            chk(q, {28'h0, mode_exp, 3'h0}, "latch one after reset");
            bus(1'b1, 8'h78, 32'h0);
            chk(q, 32'h0, "latch two after reset");
            bus(1'b1, 8'h80, 32'h0);
            chk(q, {29'h0, mode_lk, 2'h0}, "status after reset");
            lvd_trip_in <= seed[9];
            // a write without the low byte lane must neither store nor lock
            av_req.byteenable <= 4'hE;
            bus(1'b0, 8'h7C, ~v1);
            av_req.byteenable <= 4'hF;
            bus(1'b0, 8'h7C, v1);
            mode_exp = mode_lk ? mode_exp : v1[3];
            mode_lk = 1'b1;
            e1 = {24'h0, v1[7:4], mode_exp, v1[2:0]};
            bus(1'b0, 8'h7C, ~v1);
            bus(1'b0, 8'h78, v2);
            bus(1'b0, 8'h78, ~v2);
            bus(1'b1, 8'h7C, 32'h0);
            chk(q, e1, "latch one keeps first write");
            bus(1'b1, 8'h78, 32'h0);
            chk(q & 32'h3, v2 & 32'h3, "latch two keeps first write");
            bus(1'b1, 8'h80, 32'h0);
            chk(q & 32'h1F, 32'h7, "lock status");
            bus(1'b1, 8'h84, 32'h0);
            chk(q, 32'h0, "unmapped read");
            chk(32'(ctrl), 32'(exp_ctrl(e1[7:0], v2[7:0], lvd_trip_in, 1'b0)), "running controls");
            stop_req_in <= 1'b1;
            @(posedge clk_in);
            stop_req_in <= 1'b0;
            #1;
            chk(32'(ill), 32'(!e1[1]), "illegal opcode pulse");
            if (e1[1])
            begin
                repeat (2) @(posedge clk_in);
                #1;
                chk(32'(ctrl), 32'(exp_ctrl(e1[7:0], v2[7:0], lvd_trip_in, 1'b1)), "stop controls");
                @(posedge clk_in);
                bus(1'b1, 8'h80, 32'h0);
                chk(q & 32'h18, 32'h8, "stopped status");
                lb = (it == 3) || (seed[10] && it != 1);
                wake_in        <= 1'b1;
                wake_by_lvd_in <= lb;
                @(posedge clk_in);
                wake_in <= 1'b0;
                n = 0;
                while (res !== 1'b1 && n < 5000)
                begin
                    @(posedge clk_in);
                    n++;
                end
                d = (e1[2] && !lb) ? WOL_REC_SHORT_CYC : WOL_REC_LONG_CYC;
                wake_by_lvd_in <= 1'b0;
                chk(32'(n >= d && n <= d + 3), 32'h1, "recovery delay");
            end
            $display("test %0d done", it);
        end
        finish_test();
    end
endmodule
